// File: rcl_pkg.sv
/*
 rcl_pkg: shared constants for the identification code, crc and command layer.
 assumes nothing of its surroundings; imported by both ends, the checker and the testbench, not by the interface.
*/
`default_nettype none
package rcl_pkg;
	localparam int ID_W       = 64;
	localparam int FAM_W      = 8;
	localparam int SER_W      = 36;
	localparam int RNG_W      = 12;
	localparam int CRC_W      = 8;
	localparam int BODY_W     = 56;
	localparam int BYTE_W     = 8;
	localparam logic [7:0] CRC_POLY  = 8'h8c;
	localparam logic [7:0] CRC_INIT  = 8'h00;
	localparam logic [7:0] CMD_READ  = 8'h33;
	localparam logic [7:0] CMD_MATCH = 8'h55;
	localparam logic [7:0] CMD_SRCH  = 8'hf0;
	localparam logic [7:0] CMD_CSRCH = 8'hec;
	localparam logic [7:0] CMD_SKIP  = 8'hcc;
	localparam logic [7:0] CMD_OSKIP = 8'h3c;
	localparam logic [7:0] CMD_OMTCH = 8'h69;
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [5:0] ID_LAST   = 6'h3f;
	typedef enum logic [1:0] {RCL_ROM, RCL_ROMDATA, RCL_MEM} rcl_layer_t;
	// lsb-first crc step, reflected form of x^8+x^5+x^4+1
	function automatic logic [7:0] rcl_crc_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		return fb ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
	endfunction
endpackage
`default_nettype wire

// File: rcl_link_if.sv
/*
 rcl_link_if: bit-level link between bus master and device.
 assumes one clock; a bit moves when bit_vld is high for one cycle.
 master drives bits toward the device; device answers on dev_bit.
*/
`timescale 1ns/1ps
`default_nettype none
interface rcl_link_if;
	logic rst_pulse;
	logic bit_vld;
	logic bit_val;
	logic dev_vld;
	logic dev_bit;
	logic overdrive;
	modport master (output rst_pulse, output bit_vld, output bit_val,
		input dev_vld, input dev_bit, input overdrive);
	modport device (input rst_pulse, input bit_vld, input bit_val,
		output dev_vld, output dev_bit, output overdrive);
endinterface
`default_nettype wire

// File: rcl_device.sv
/*
 rcl_device: device end; fixed identification code with its crc, rom layer gate
 and overdrive switch. assumes the master sends whole lsb-first bytes and a
 reset pulse before each transaction.
*/
`timescale 1ns/1ps
`default_nettype none
module rcl_device
	import rcl_pkg::*;
#(
	parameter logic [7:0]  FAMILY = 8'h5a,     // arbitrary value
	parameter logic [35:0] SERIAL = 36'h123456789,
	parameter logic [11:0] RANGE  = 12'habc    // arbitrary value
) (
	input  wire logic  core_clk,
	input  wire logic  sys_rst,
	rcl_link_if.device link,
	output logic       mem_cmd_vld,
	output logic [7:0] mem_cmd,
	output logic       mem_open
);
	logic [7:0]    crc_q, crc_d;
	logic [5:0]    idx_q, idx_d;
	logic          crc_done_q, crc_done_d;
	logic [ID_W-1:0] rom_code;
	rcl_layer_t    lay_q, lay_d;
	logic [7:0]    sh_q, sh_d;
	logic [2:0]    cnt_q, cnt_d;
	logic [5:0]    rd_q, rd_d;
	logic          od_q, od_d, dv_q, dv_d, db_q, db_d, cv_q, cv_d;
	logic [7:0]    cmd_q, cmd_d;
	logic [7:0]    byte_in;

	assign rom_code = {crc_q, RANGE, SERIAL, FAMILY};

	// crc built bit by bit after reset over the 56 body bits
	always_comb begin
		crc_d      = crc_q;
		idx_d      = idx_q;
		crc_done_d = crc_done_q;
		if (!crc_done_q) begin
			crc_d = rcl_crc_step(crc_q, rom_code[idx_q]);
			idx_d = idx_q + 6'h01;
			if (idx_q == 6'(BODY_W - 1))
				crc_done_d = 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			crc_q      <= CRC_INIT;
			idx_q      <= 6'h00;
			crc_done_q <= 1'b0;
		end else begin
			crc_q      <= crc_d;
			idx_q      <= idx_d;
			crc_done_q <= crc_done_d;
		end
	end

	assign byte_in = {link.bit_val, sh_q[7:1]};

	always_comb begin
		lay_d = lay_q;
		sh_d  = sh_q;
		cnt_d = cnt_q;
		rd_d  = rd_q;
		od_d  = od_q;
		dv_d  = 1'b0;
		db_d  = db_q;
		cv_d  = 1'b0;
		cmd_d = cmd_q;
		if (link.rst_pulse) begin
			lay_d = RCL_ROM;
			cnt_d = 3'h0;
			rd_d  = 6'h00;
		end else if (lay_q == RCL_ROMDATA && link.bit_vld && crc_done_q) begin
			dv_d = 1'b1;
			db_d = rom_code[rd_q];
			rd_d = rd_q + 6'h01;
			if (rd_q == ID_LAST)
				lay_d = RCL_MEM;
		end else if (link.bit_vld && lay_q != RCL_ROMDATA) begin
			sh_d  = byte_in;
			cnt_d = cnt_q + 3'h1;
			if (cnt_q == BIT_LAST) begin
				unique case (lay_q)
					RCL_ROM: begin
						if (byte_in == CMD_READ)
							lay_d = RCL_ROMDATA;
						else if (byte_in == CMD_SKIP)
							lay_d = RCL_MEM;
						else if (byte_in == CMD_OSKIP) begin
							lay_d = RCL_MEM;
							od_d  = 1'b1;
						end
						// match and search families: not handled, stays in rom layer
					end
					RCL_MEM: begin
						cv_d  = 1'b1;
						cmd_d = byte_in;
					end
					default: lay_d = RCL_ROM;
				endcase
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lay_q <= RCL_ROM;
			sh_q  <= 8'h00;
			cnt_q <= 3'h0;
			rd_q  <= 6'h00;
			od_q  <= 1'b0;
			dv_q  <= 1'b0;
			db_q  <= 1'b0;
			cv_q  <= 1'b0;
			cmd_q <= 8'h00;
		end else begin
			lay_q <= lay_d;
			sh_q  <= sh_d;
			cnt_q <= cnt_d;
			rd_q  <= rd_d;
			od_q  <= od_d;
			dv_q  <= dv_d;
			db_q  <= db_d;
			cv_q  <= cv_d;
			cmd_q <= cmd_d;
		end
	end

	assign link.overdrive = od_q;
	assign link.dev_vld   = dv_q;
	assign link.dev_bit   = db_q;
	assign mem_cmd_vld    = cv_q;
	assign mem_cmd        = cmd_q;
	assign mem_open       = (lay_q == RCL_MEM);
endmodule
`default_nettype wire

// File: rcl_master.sv
/*
 rcl_master: bus master end; issues a reset pulse, a rom command and an optional
 memory command; after a read command it reads the 64-bit code and checks its crc.
 assumes the device answers each read slot one cycle after bit_vld.
*/
`timescale 1ns/1ps
`default_nettype none
module rcl_master
	import rcl_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  sys_rst,
	rcl_link_if.master link,
	input  wire logic  start,
	input  wire logic [7:0] rom_cmd,
	input  wire logic  mem_en,
	input  wire logic [7:0] mem_cmd,
	output logic       busy,
	output logic       done,
	output logic       crc_ok,
	output logic [63:0] id_code
);
	typedef enum logic [2:0] {RM_IDLE, RM_RST, RM_ROM, RM_READ, RM_WAIT, RM_MEM} rcl_mst_t;
	rcl_mst_t      st_q, st_d;
	logic [7:0]    sh_q, sh_d, crc_q, crc_d;
	logic [2:0]    cnt_q, cnt_d;
	logic [5:0]    rc_q, rc_d;
	logic [63:0]   id_q, id_d;
	logic          rp_q, rp_d, bv_q, bv_d, bb_q, bb_d, dn_q, dn_d, ok_q, ok_d, me_q, me_d;
	logic [7:0]    mc_q, mc_d;

	always_comb begin
		st_d = st_q; sh_d = sh_q; crc_d = crc_q; cnt_d = cnt_q; rc_d = rc_q;
		id_d = id_q; rp_d = 1'b0; bv_d = 1'b0; bb_d = bb_q; dn_d = 1'b0;
		ok_d = ok_q; me_d = me_q; mc_d = mc_q;
		unique case (st_q)
			RM_IDLE: if (start) begin
				st_d = RM_RST; rp_d = 1'b1; sh_d = rom_cmd; me_d = mem_en; mc_d = mem_cmd;
			end
			RM_RST: begin
				st_d = RM_ROM; cnt_d = 3'h0;
			end
			RM_ROM, RM_MEM: begin
				bv_d = 1'b1;
				bb_d = sh_q[0];
				sh_d = sh_q >> 1;
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == BIT_LAST) begin
					if (st_q == RM_ROM && sh_q == 8'h00 && rom_cmd == CMD_READ) begin
						st_d = RM_READ; rc_d = 6'h00; crc_d = CRC_INIT;
					end else if (st_q == RM_ROM && me_q) begin
						st_d = RM_MEM; sh_d = mc_q;
					end else begin
						st_d = RM_IDLE; dn_d = 1'b1;
					end
				end
			end
			RM_READ: begin
				bv_d = 1'b1; st_d = RM_WAIT;
			end
			RM_WAIT: if (link.dev_vld) begin
				id_d  = {link.dev_bit, id_q[63:1]};
				crc_d = rcl_crc_step(crc_q, link.dev_bit);
				rc_d  = rc_q + 6'h01;
				if (rc_q == ID_LAST) begin
					ok_d = (rcl_crc_step(crc_q, link.dev_bit) == CRC_INIT);
					if (me_q) begin
						st_d = RM_MEM; sh_d = mc_q; cnt_d = 3'h0;
					end else begin
						st_d = RM_IDLE; dn_d = 1'b1;
					end
				end else
					st_d = RM_READ;
			end
			default: st_d = RM_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= RM_IDLE; sh_q <= 8'h00; crc_q <= CRC_INIT; cnt_q <= 3'h0;
			rc_q <= 6'h00; id_q <= 64'h0; rp_q <= 1'b0; bv_q <= 1'b0; bb_q <= 1'b0;
			dn_q <= 1'b0; ok_q <= 1'b0; me_q <= 1'b0; mc_q <= 8'h00;
		end else begin
			st_q <= st_d; sh_q <= sh_d; crc_q <= crc_d; cnt_q <= cnt_d;
			rc_q <= rc_d; id_q <= id_d; rp_q <= rp_d; bv_q <= bv_d; bb_q <= bb_d;
			dn_q <= dn_d; ok_q <= ok_d; me_q <= me_d; mc_q <= mc_d;
		end
	end
	assign link.rst_pulse = rp_q;
	assign link.bit_vld   = bv_q;
	assign link.bit_val   = bb_q;
	assign busy    = (st_q != RM_IDLE);
	assign done    = dn_q;
	assign crc_ok  = ok_q;
	assign id_code = id_q;
endmodule
`default_nettype wire

// File: rcl_chk.sv
/*
 rcl_chk: concurrent checks on the bit link between master and device ends.
 assumes the interface signals as plain inputs, one clock and a sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rcl_chk
	import rcl_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rst_pulse,
	input wire logic bit_vld,
	input wire logic bit_val,
	input wire logic dev_vld,
	input wire logic dev_bit,
	input wire logic overdrive
);
	logic [6:0] bcnt_q;
	logic [6:0] rcnt_q;
	logic [7:0] sh_q;
	logic [7:0] crc_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// rom byte bits saturate at 8, so later read slots leave the byte alone
	always_ff @(posedge core_clk) begin
		if (sys_rst || rst_pulse) begin
			bcnt_q <= 7'h00;
			rcnt_q <= 7'h00;
			crc_q <= 8'h00;
		end else begin
			if (bit_vld && bcnt_q < 7'h08) begin
				bcnt_q <= bcnt_q + 7'h01;
				sh_q <= {bit_val, sh_q[7:1]};
			end
			if (dev_vld) begin
				rcnt_q <= rcnt_q + 7'h01;
				crc_q <= (crc_q >> 1) ^ ((crc_q[0] ^ dev_bit) ? 8'h8c : 8'h00);
			end
		end
	end
	sequence s_open;
		rst_pulse ##1 !bit_vld;
	endsequence
	sequence s_rom_byte;
		bit_vld [*8];
	endsequence
	open_order_a:
		assert property (s_open |=> s_rom_byte) else $error("rom byte order");
	slot_answer_a:
		assert property (dev_vld |-> $past(bit_vld)) else $error("late answer");
	read_count_a:
		assert property (dev_vld |-> rcnt_q < 7'h40) else $error("read count");
	first_read_a:
		assert property (dev_vld && rcnt_q == 7'h00 |-> bcnt_q == 7'h08) else $error("early read");
	crc_zero_a:
		assert property (dev_vld && rcnt_q == 7'h3f |=> crc_q == 8'h00) else $error("crc residue");
	ovd_cause_a:
		assert property ($rose(overdrive) |-> bcnt_q == 7'h08 && sh_q == CMD_OSKIP)
			else $error("overdrive cause");
	ovd_hold_a:
		assert property (overdrive |=> overdrive) else $error("overdrive dropped");
	rst_clear_a:
		assert property ($fell(sys_rst) |-> !overdrive && !dev_vld) else $error("reset state");
endmodule
`default_nettype wire

// File: rcl_tb.sv
/*
 rcl_tb: drives the master end against the device end with rom commands.
 assumes the package, interface, both ends and rcl_chk are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rcl_tb
	import rcl_pkg::*;
;
	localparam logic [7:0]  FAM = 8'h3d;        // arbitrary value
	localparam logic [35:0] SER = 36'h0f1e2d3c4;
	localparam logic [11:0] RNG = 12'h5a6;      // arbitrary value
	logic        core_clk, sys_rst, start, mem_en, busy, done, crc_ok, mem_cmd_vld, mem_open;
	logic [7:0]  rom_cmd, mem_cmd, dev_cmd, crc, last_cmd;
	logic [7:0]  refused [4] = '{CMD_MATCH, CMD_SRCH, CMD_CSRCH, CMD_OMTCH};
	logic [63:0] id_code, exp_id;
	logic [55:0] body;
	int          miscompares, checks_done, vld_n;
	rcl_link_if link();
	rcl_device #(.FAMILY(FAM), .SERIAL(SER), .RANGE(RNG)) u_rcl_device (.core_clk(core_clk),
		.sys_rst(sys_rst), .link(link), .mem_cmd_vld(mem_cmd_vld), .mem_cmd(dev_cmd),
		.mem_open(mem_open));
	rcl_master u_rcl_master (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .start(start),
		.rom_cmd(rom_cmd), .mem_en(mem_en), .mem_cmd(mem_cmd), .busy(busy), .done(done),
		.crc_ok(crc_ok), .id_code(id_code));
	rcl_chk u_rcl_chk (.core_clk(core_clk), .sys_rst(sys_rst), .rst_pulse(link.rst_pulse),
		.bit_vld(link.bit_vld), .bit_val(link.bit_val), .dev_vld(link.dev_vld),
		.dev_bit(link.dev_bit), .overdrive(link.overdrive));
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (mem_cmd_vld === 1'b1) begin
			vld_n++;
			last_cmd = dev_cmd;
		end
	end
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	// done is a one-cycle pulse, so it is looked at on every falling edge
	task run(input logic [7:0] rc, input logic me, input logic [7:0] mc);
		int i;
		@(negedge core_clk);
		start = 1'b1;
		rom_cmd = rc;
		mem_en = me;
		mem_cmd = mc;
		@(negedge core_clk);
		start = 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge core_clk);
		if (i == 400) begin
			miscompares++;
			wrap_up;
		end
		repeat (3) @(negedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		start = 1'b0;
		mem_en = 1'b0;
		rom_cmd = 8'h00;
		mem_cmd = 8'h00;
		crc = 8'h00;
		body = {RNG, SER, FAM};
		for (int k = 0; k < 56; k++) crc = (crc >> 1) ^ ((crc[0] ^ body[k]) ? 8'h8c : 8'h00);
		exp_id = {crc, body};
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		// the device rebuilds its crc after reset, so no request before then
		repeat (60) @(negedge core_clk);
		run(CMD_READ, 1'b0, 8'h00);
		chk("id_code", exp_id, id_code);
		chk("crc_ok", 64'h1, crc_ok);
		run(CMD_SKIP, 1'b1, 8'ha5);
		chk("skip", {8'h01, 8'ha5, 8'h00}, {vld_n[7:0], last_cmd, 7'h00, link.overdrive});
		chk("mem_open", 64'h1, mem_open);
		for (int k = 0; k < 4; k++) begin
			run(refused[k], 1'b1, 8'h5a);
			chk("refused", {8'h01, 8'h00}, {vld_n[7:0], 7'h00, mem_open});
		end
		run(CMD_OSKIP, 1'b1, 8'h0f);
		chk("oskip", {8'h02, 8'h0f, 8'h01}, {vld_n[7:0], last_cmd, 7'h00, link.overdrive});
		run(CMD_READ, 1'b0, 8'h00);
		chk("fast id", {exp_id[62:0], link.overdrive}, {id_code[62:0], 1'b1});
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		@(negedge core_clk);
		chk("ovd clear", 64'h0, link.overdrive);
		wrap_up;
	end
endmodule
`default_nettype wire
